// File: sbe_host.sv
// Host model issuing command strobes to the status block.
// Assumes one-cycle strobes and an answer one cycle later.
`timescale 1ns/1ps
module sbe_host (
   // Clock and answer
   input  wire logic       ref_clk,
   input  wire logic [7:0] rd_data_r,
   input  wire logic       rd_valid_r,
   // Strobes and write value
   output logic [8:0]      cmd,
   output logic [7:0]      wr_data
);
   initial begin
      cmd = 9'h000;
      wr_data = 8'h00;
   end
   // One strobe; unknown answer if none came back
   task op(input int k, input logic [7:0] d, output logic [7:0] q);
      @(posedge ref_clk);
      #1 cmd = 9'h001 << k;
      wr_data = d;
      @(posedge ref_clk);
      #1 cmd = 9'h000;
      wr_data = ~d;
      q = rd_valid_r ? rd_data_r : 8'hxx;
   endtask
   // Paced host: poll up to eight times until the message bit reaches lvl
   task wait_mav(input logic lvl, output logic [7:0] q);
      for (int n = 0; n < 8; n++) begin
         op(0, 8'h00, q);
         if (q[4] === lvl) break;
      end
   endtask
endmodule // sbe_host

// File: sbe_map.vh
// Constants for the status byte and standard event reporting block.
// Assumes it is included by bare name from every design file that needs it.
`ifndef SBE_MAP_VH
`define SBE_MAP_VH

// Width of every status register
`define SBE_W         8

// Status byte bit positions
`define SBE_SB_OPE    7
`define SBE_SB_RQS    6
`define SBE_SB_ESB    5
`define SBE_SB_MAV    4

// Standard event status bit positions
`define SBE_EV_PON    7
`define SBE_EV_URQ    6
`define SBE_EV_CME    5
`define SBE_EV_EXE    4
`define SBE_EV_DDE    3
`define SBE_EV_QYE    2
`define SBE_EV_RQC    1
`define SBE_EV_OPC    0

// Reset values
`define SBE_EV_RST    8'h80
`define SBE_EVMK_RST  8'h00
`define SBE_SRE_RST   8'h00
`define SBE_ZERO8     8'h00

// Bits of the service request enable that hold a value
`define SBE_SRE_MASK  8'hbf

// Default width of the operation event summary inputs
`define SBE_OPW       16

`endif

// File: sbe_status.v
// Status byte, service request and standard event status logic.
// Assumes a command parser drives one-cycle strobes synchronous to
// ref_clk, and that rst is the power-on reset of the instrument.
`timescale 1ns/1ps
`include "sbe_map.vh"

// Notes on behaviour
// - Service request when any enabled status bit set
// - Bit 6 is RQS on poll, MSS on query
// - Operation summary set; cleared by device clear, read
// - Event summary follows enabled standard event bits
// - Message available while responses remain pending
// - Unused status and event bits read zero
// - Values are sums of set bit weights
// - Event bit counts only when enable bit set
// - Power-on bit set at power-up only
// - Command error on syntax error
// - Execution error on bad or contradictory parameter
// - Device error on error queue overflow
// - Query error on empty read or lost data
// - Operation complete after prior commands finish
// - Event status cleared by read, clear, power-up
// - Event enable cleared only by write or power
// - RQS clears on poll or device clear
// - Operation bit counts only when enabled
module sbe_status #(
   parameter OPW = `SBE_OPW  // Width of the operation event inputs
) (
   // Clock and power-on reset
   input  wire                ref_clk,
   input  wire                rst,
   // Interface clear commands
   input  wire                dev_clr,
   input  wire                cls_cmd,
   // Read requests, one-cycle strobes
   input  wire                spoll_rd,
   input  wire                sbyte_qry,
   input  wire                evst_qry,
   input  wire                evmk_qry,
   input  wire                sre_qry,
   // Register writes
   input  wire                evmk_wr,
   input  wire                sre_wr,
   input  wire [`SBE_W-1:0]   wr_data,
   // Error and completion events, one-cycle strobes
   input  wire                cmd_err,
   input  wire                exe_err,
   input  wire                queue_ovf,
   input  wire                qry_err,
   input  wire                opc_cmd,
   // Parser and output buffer levels
   input  wire                cmd_busy,
   input  wire                resp_ready,
   // Operation status summary sources
   input  wire [OPW-1:0]      oper_event,
   input  wire [OPW-1:0]      oper_enable,
   // Read answer
   output reg  [`SBE_W-1:0]   rd_data_r,
   output reg                 rd_valid_r,
   // Service request line and live status byte
   output reg                 srq_r,
   output reg  [`SBE_W-1:0]   status_byte_r
);

   // Enable registers
   reg  [`SBE_W-1:0] evmk_r;       // Standard event enable
   reg  [`SBE_W-1:0] sre_r;        // Service request enable

   // Request service latch and its edge detector
   reg               rqs_r;        // Request service flag
   reg               rqs_nxt;      // Next request service flag
   reg               mss_prev_r;   // Master summary, previous cycle

   // Operation complete tracking
   reg               opc_pend_r;   // An *OPC style marker is waiting
   reg               opc_pend_nxt; // Next pending state
   reg               opc_done;     // Marker reached, set the flag

   // Read arbitration
   reg               sel_spoll;    // Serial poll served
   reg               sel_sbyte;    // Status byte query served
   reg               sel_evst;     // Event status query served
   reg               sel_evmk;     // Event enable query served
   reg               sel_sre;      // Request enable query served
   reg  [`SBE_W-1:0] rd_nxt;       // Next read answer
   reg               rd_vld_nxt;   // Next read valid

   // Sticky flag controls
   reg  [`SBE_W-1:0] evst_set;     // Event status set strobes
   reg  [`SBE_W-1:0] evst_clr;     // Event status clear strobes
   wire [`SBE_W-1:0] evst_q;       // Event status contents
   reg               ope_set;      // Operation summary set
   reg               ope_clr;      // Operation summary clear
   wire              ope_q;        // Operation summary flag

   // Combinational summaries
   reg               esb;          // Event summary bit
   reg               mav;          // Message available bit
   reg               oper_any;     // Any enabled operation event
   reg  [`SBE_W-1:0] sbyte_base;   // Status byte without bit 6
   reg               mss;          // Master summary status
   reg  [`SBE_W-1:0] sbyte_mss;    // Status byte as queried
   reg  [`SBE_W-1:0] sbyte_rqs;    // Status byte as polled

   // Only one read is answered per cycle; the parser issues one at a
   // time, and a serial poll wins because it comes from the bus layer
   always @* begin
      sel_spoll = spoll_rd;
      sel_sbyte = 1'b0;
      sel_evst  = 1'b0;
      sel_evmk  = 1'b0;
      sel_sre   = 1'b0;
      if (spoll_rd) begin
         sel_spoll = 1'b1;
      end else if (sbyte_qry) begin
         sel_sbyte = 1'b1;
      end else if (evst_qry) begin
         sel_evst = 1'b1;
      end else if (evmk_qry) begin
         sel_evmk = 1'b1;
      end else if (sre_qry) begin
         sel_sre = 1'b1;
      end
   end

   // Operation summary source, masked per bit
   always @* begin
      oper_any = |(oper_event & oper_enable);
   end

   // Operation complete waits for the parser to drain
   always @* begin
      opc_done     = 1'b0;
      opc_pend_nxt = opc_pend_r;
      if (opc_cmd) begin
         // Marker itself still counts as in flight this cycle
         opc_pend_nxt = 1'b1;
      end else if (opc_pend_r && !cmd_busy) begin
         opc_done     = 1'b1;
         opc_pend_nxt = 1'b0;
      end
   end

   // Event status set and clear strobes
   always @* begin
      evst_set = `SBE_ZERO8;
      // User request and request control are never set
      evst_set[`SBE_EV_CME] = cmd_err;
      evst_set[`SBE_EV_EXE] = exe_err;
      evst_set[`SBE_EV_DDE] = queue_ovf;
      evst_set[`SBE_EV_QYE] = qry_err;
      evst_set[`SBE_EV_OPC] = opc_done;
      // Power-on bit has no set strobe, only its reset value
      evst_clr = {`SBE_W{sel_evst | cls_cmd}};
   end

   // Event status register
   sbe_sticky #(
      .W       (`SBE_W),
      .RST_VAL (`SBE_EV_RST)
   ) u_evst (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set_i   (evst_set),
      .clr_i   (evst_clr),
      .q_r     (evst_q)
   );

   // Operation summary latch controls
   always @* begin
      ope_set = oper_any;
      ope_clr = dev_clr | sel_spoll | sel_sbyte;
   end

   // Operation summary latch; a still-active source sets it again
   sbe_sticky #(
      .W       (1),
      .RST_VAL (1'b0)
   ) u_ope (
      .ref_clk (ref_clk),
      .rst     (rst),
      .set_i   (ope_set),
      .clr_i   (ope_clr),
      .q_r     (ope_q)
   );

   // Status byte summaries, recomputed from current state
   always @* begin
      esb = |(evst_q & evmk_r);
      mav = resp_ready;
      sbyte_base = `SBE_ZERO8;
      sbyte_base[`SBE_SB_OPE] = ope_q;
      sbyte_base[`SBE_SB_ESB] = esb;
      sbyte_base[`SBE_SB_MAV] = mav;
      // Bit 6 of the enable is ignored by the mask constant
      mss = |(sbyte_base & sre_r);
   end

   // Two views of bit 6
   always @* begin
      sbyte_mss = sbyte_base;
      sbyte_rqs = sbyte_base;
      sbyte_mss[`SBE_SB_RQS] = mss;
      sbyte_rqs[`SBE_SB_RQS] = rqs_r;
   end

   // Request service: set when a new request goes out
   always @* begin
      rqs_nxt = rqs_r;
      if (mss && !mss_prev_r) begin
         // A new request wins over a poll in the same cycle
         rqs_nxt = 1'b1;
      end else if (dev_clr || sel_spoll) begin
         rqs_nxt = 1'b0;
      end
   end

   // Read answer mux; values are plain weight sums of the bits
   always @* begin
      rd_nxt     = `SBE_ZERO8;
      rd_vld_nxt = 1'b1;
      if (sel_spoll) begin
         rd_nxt = sbyte_rqs;
      end else if (sel_sbyte) begin
         rd_nxt = sbyte_mss;
      end else if (sel_evst) begin
         // Captured before the clear takes effect
         rd_nxt = evst_q;
      end else if (sel_evmk) begin
         rd_nxt = evmk_r;
      end else if (sel_sre) begin
         rd_nxt = sre_r;
      end else begin
         rd_vld_nxt = 1'b0;
      end
   end

   // Standard event enable: only a write or power-up changes it
   always @(posedge ref_clk) begin
      if (rst) begin
         evmk_r <= `SBE_EVMK_RST;
      end else if (evmk_wr) begin
         evmk_r <= wr_data;
      end
   end

   // Service request enable; bit 6 cannot be enabled
   always @(posedge ref_clk) begin
      if (rst) begin
         sre_r <= `SBE_SRE_RST;
      end else if (sre_wr) begin
         sre_r <= wr_data & `SBE_SRE_MASK;
      end
   end

   // Request service state and edge history
   always @(posedge ref_clk) begin
      if (rst) begin
         rqs_r      <= 1'b0;
         mss_prev_r <= 1'b0;
      end else begin
         rqs_r      <= rqs_nxt;
         mss_prev_r <= mss;
      end
   end

   // Operation complete marker
   always @(posedge ref_clk) begin
      if (rst) begin
         opc_pend_r <= 1'b0;
      end else begin
         opc_pend_r <= opc_pend_nxt;
      end
   end

   // Registered read port
   always @(posedge ref_clk) begin
      if (rst) begin
         rd_data_r  <= `SBE_ZERO8;
         rd_valid_r <= 1'b0;
      end else begin
         rd_data_r  <= rd_nxt;
         rd_valid_r <= rd_vld_nxt;
      end
   end

   // Registered request line and status view
   // Status view lags the state by one cycle; srq_r loads rqs_nxt so it matches rqs_r; every port is a flop
   always @(posedge ref_clk) begin
      if (rst) begin
         srq_r         <= 1'b0;
         status_byte_r <= `SBE_ZERO8;
      end else begin
         srq_r         <= rqs_nxt;
         status_byte_r <= sbyte_mss;
      end
   end

endmodule // sbe_status

// File: sbe_status_asserts.sv
// Checker for the status byte and event reporting block.
// Assumes it is bound onto sbe_status and sees only its ports.
`timescale 1ns/1ps
module sbe_status_asserts #(
   parameter OPW = 16  // Operation source width
) (
   // Clock, reset, commands and events
   input wire logic           ref_clk, rst, dev_clr, cls_cmd,
   input wire logic           spoll_rd, sbyte_qry, evst_qry, evmk_qry, sre_qry,
   input wire logic           evmk_wr, sre_wr, cmd_err, exe_err, queue_ovf,
   input wire logic           qry_err, opc_cmd, cmd_busy, resp_ready,
   input wire logic [7:0]     wr_data,
   input wire logic [OPW-1:0] oper_event, oper_enable,
   // Answers
   input wire logic [7:0]     rd_data_r, status_byte_r,
   input wire logic           rd_valid_r, srq_r
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Reads after priority
   wire        any_rd = spoll_rd | sbyte_qry | evst_qry | evmk_qry | sre_qry;
   wire        evt_rd = evst_qry & ~spoll_rd & ~sbyte_qry;
   wire        en_rd  = evmk_qry & ~spoll_rd & ~sbyte_qry & ~evst_qry;
   logic [7:0] en_s_r;  // Shadow of the event enable
   // Follows writes only, so any other clear shows up
   always @(posedge ref_clk) begin
      if (rst) en_s_r <= 8'h00;
      else if (evmk_wr) en_s_r <= wr_data;
   end
   sequence ope_src; |(oper_event & oper_enable); endsequence
   sequence clr_hi; (spoll_rd | dev_clr) && status_byte_r[6]; endsequence
   rd_pulse_a: assert property (rd_valid_r == $past(any_rd))
      else $error("read answer pulse wrong");
   low_bits_a: assert property (status_byte_r[3:0] == 4'h0)
      else $error("unused status bits set");
   evt_unused_a: assert property (rd_valid_r && $past(evt_rd) |-> !rd_data_r[6] && !rd_data_r[1])
      else $error("unused event bits set");
   mav_track_a: assert property (status_byte_r[4] == $past(resp_ready))
      else $error("message bit wrong");
   srq_rise_a: assert property ($rose(status_byte_r[6]) |-> srq_r)
      else $error("service request late");
   rqs_clear_a: assert property (clr_hi |=> !srq_r)
      else $error("request flag not cleared");
   poll_bit_a: assert property (rd_valid_r && $past(spoll_rd) |-> rd_data_r[6] == $past(srq_r))
      else $error("poll bit six wrong");
   ope_set_a: assert property (ope_src |-> ##2 status_byte_r[7])
      else $error("operation summary not set");
   en_read_a: assert property (rd_valid_r && $past(en_rd) |-> rd_data_r == $past(en_s_r))
      else $error("event enable read wrong");
   reset_zero_a: assert property (disable iff (1'b0) rst |=> !rd_valid_r && !srq_r && status_byte_r == 8'h00)
      else $error("outputs not cleared by reset");
endmodule // sbe_status_asserts

bind sbe_status sbe_status_asserts #(.OPW(OPW)) i_sbe_status_asserts (.*);

// File: sbe_status_tb.sv
// Testbench for the status byte and event reporting block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module sbe_status_tb;
   localparam int P_POLL = 0, P_SUM = 1, P_EVT = 2, P_EN = 3, P_SRQE = 4;
   localparam int P_ENW = 5, P_SRQW = 6, P_DCL = 7, P_CLS = 8;
   logic        ref_clk = 1'b0;  // 200 MHz clock
   logic        rst = 1'b1;      // Power-on reset
   logic [3:0]  ev = 4'h0;       // Error strobes, bit i sets event bit i+2
   logic        opc_cmd = 1'b0, cmd_busy = 1'b0, resp_ready = 1'b0;
   logic [15:0] oper_event = 16'h0000, oper_enable = 16'h0000;
   logic [8:0]  cmd;
   logic [7:0]  wr_data, rd_data_r, status_byte_r, q;
   logic        rd_valid_r, srq_r;
   int          fails = 0, checks = 0, cyc = 0;
   sbe_host i_sbe_host (.ref_clk(ref_clk), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
      .cmd(cmd), .wr_data(wr_data));
   sbe_status #(.OPW(16)) i_sbe_status (.ref_clk(ref_clk), .rst(rst), .dev_clr(cmd[7]),
      .cls_cmd(cmd[8]), .spoll_rd(cmd[0]), .sbyte_qry(cmd[1]), .evst_qry(cmd[2]),
      .evmk_qry(cmd[3]), .sre_qry(cmd[4]), .evmk_wr(cmd[5]), .sre_wr(cmd[6]),
      .wr_data(wr_data), .cmd_err(ev[3]), .exe_err(ev[2]), .queue_ovf(ev[1]),
      .qry_err(ev[0]), .opc_cmd(opc_cmd), .cmd_busy(cmd_busy), .resp_ready(resp_ready),
      .oper_event(oper_event), .oper_enable(oper_enable), .rd_data_r(rd_data_r),
      .rd_valid_r(rd_valid_r), .srq_r(srq_r), .status_byte_r(status_byte_r));
   initial forever #2.5 ref_clk = ~ref_clk;
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task r(input int k); i_sbe_host.op(k, 8'h00, q); endtask
   task w(input int k, input logic [7:0] d); i_sbe_host.op(k, d, q); endtask
   task pulse(input int k);
      @(posedge ref_clk);
      #1 ev[k] = 1'b1;
      @(posedge ref_clk);
      #1 ev[k] = 1'b0;
   endtask
   task hold(input int n); repeat (n) @(posedge ref_clk); #1; endtask
   // Hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         complete_run;
      end
   end
   initial begin
      hold(16);
      rst = 1'b0;
      r(P_EVT); chk(q, 8'h80);
      r(P_EVT); chk(q, 8'h00);
      r(P_EN); chk(q, 8'h00);
      for (int i = 0; i < 4; i++) begin
         pulse(i); r(P_EVT); chk(q, 8'h04 << i);
      end
      cmd_busy = 1'b1;
      opc_cmd = 1'b1;
      hold(1);
      opc_cmd = 1'b0;
      hold(3); r(P_EVT); chk(q, 8'h00);
      cmd_busy = 1'b0;
      hold(2); r(P_EVT); chk(q, 8'h01);
      pulse(3); w(P_CLS, 8'h00); r(P_EVT); chk(q, 8'h00);
      w(P_ENW, 8'h20); r(P_EN); chk(q, 8'h20);
      pulse(2); r(P_SUM); chk(q, 8'h00);
      pulse(3); r(P_SUM); chk(q, 8'h20);
      w(P_CLS, 8'h00); w(P_DCL, 8'h00); r(P_EN); chk(q, 8'h20);
      r(P_SUM); chk(q, 8'h00);
      w(P_SRQW, 8'hff); r(P_SRQE); chk(q, 8'hbf);
      pulse(3); r(P_SUM); chk(q, 8'h60);
      chk({7'h00, srq_r}, 8'h01);
      r(P_POLL); chk(q, 8'h60);
      r(P_SUM); chk({q[7:1], srq_r}, 8'h60);
      w(P_CLS, 8'h00); r(P_SUM); chk(q, 8'h00);
      oper_event = 16'h0010;
      hold(3); r(P_SUM); chk(q & 8'h80, 8'h00);
      oper_enable = 16'h0010;
      hold(3); r(P_SUM); chk(q & 8'h80, 8'h80);
      oper_event = 16'h0000;
      r(P_POLL); r(P_SUM); chk(q & 8'h80, 8'h00);
      oper_event = 16'h0010;
      hold(3);
      oper_event = 16'h0000;
      w(P_DCL, 8'h00); r(P_SUM); chk(q & 8'h80, 8'h00);
      resp_ready = 1'b1;
      i_sbe_host.wait_mav(1'b1, q); chk(q & 8'h10, 8'h10);
      resp_ready = 1'b0;
      i_sbe_host.wait_mav(1'b0, q); chk(q & 8'h10, 8'h00);
      complete_run;
   end
endmodule // sbe_status_tb

// File: sbe_sticky.v
// Bank of sticky flags: hardware sets, a clear strobe resets.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "sbe_map.vh"

module sbe_sticky #(
   parameter         W       = `SBE_W,    // Number of flags
   parameter [W-1:0] RST_VAL = {W{1'b0}}  // Value after reset
) (
   // Clock and reset
   input  wire         ref_clk,
   input  wire         rst,
   // Per-bit set and clear
   input  wire [W-1:0] set_i,
   input  wire [W-1:0] clr_i,
   // Flag state
   output reg  [W-1:0] q_r
);

   reg [W-1:0] q_nxt;  // Next flag state

   // Set beats clear so an event on the clear cycle survives
   always @* begin
      q_nxt = set_i | (q_r & ~clr_i);
   end

   // Flag storage
   always @(posedge ref_clk) begin
      if (rst) begin
         q_r <= RST_VAL;
      end else begin
         q_r <= q_nxt;
      end
   end

endmodule // sbe_sticky
